// >>> verilog/qsq_pkg.sv
// qsq_pkg: constants for the queued serial transmit/receive buffer block.
// assumes word-indexed register addresses on a plain strobe port.
`default_nettype none
package qsq_pkg;
  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam int FRAME_W = 9;
  localparam int PTR_W = 4;
  // ----------------------------------------------------------------
  // register map (word index on the address port)
  // ----------------------------------------------------------------
  localparam logic [5:0] A_QCTRL = 6'h00; // queue_control_reg
  localparam logic [5:0] A_QSTAT = 6'h01; // queue_status_reg
  localparam logic [5:0] A_CCTRL = 6'h02; // channel_control_reg1
  localparam logic [5:0] A_CSTAT = 6'h03; // channel_status_reg
  localparam logic [5:0] A_CDATA = 6'h04; // channel_data_reg
  localparam logic [1:0] A_TXSLOT = 2'h1; // addr[5:4] for tx_queue_slot 0..15
  localparam logic [1:0] A_RXSLOT = 2'h2; // addr[5:4] for rx_queue_slot 0..15
  // ----------------------------------------------------------------
  // queue_control_reg fields
  // ----------------------------------------------------------------
  localparam int QC_TXQEN = 0;
  localparam int QC_RXQEN = 1;
  localparam int QC_WRAP = 2;
  localparam int QC_TTIE = 3;
  localparam int QC_TBIE = 4;
  localparam int QC_RTIE = 5;
  localparam int QC_RBIE = 6;
  localparam int QC_TEST = 7;
  localparam int QC_SIZE = 8; // 4 bits
  // ----------------------------------------------------------------
  // queue_status_reg fields
  // ----------------------------------------------------------------
  localparam int QS_OVR = 0;
  localparam int QS_RTF = 1;
  localparam int QS_RBF = 2;
  localparam int QS_TTE = 3;
  localparam int QS_TBE = 4;
  localparam int QS_RPTR = 8; // 4 bits
  localparam int QS_PEND = 12; // 4 bits
  localparam int QS_TPTR = 16; // 4 bits
  // ----------------------------------------------------------------
  // channel_control_reg1 and channel_status_reg fields
  // ----------------------------------------------------------------
  localparam int CC_XON = 0;
  localparam int CC_RON = 1;
  localparam int CC_QIE = 2;
  localparam int CS_TXE = 0;
  localparam int CS_DONE = 1;
  localparam int CS_RXF = 2;
  localparam int CS_IDLE = 3;
  localparam int CS_OVR = 4;
  localparam int CS_NOISE = 5;
  localparam int CS_FRM = 6;
  localparam int CS_PAR = 7;
  // ----------------------------------------------------------------
  // reset values and special counts
  // ----------------------------------------------------------------
  localparam logic [3:0] PEND_DONE = 4'hF; // pending count meaning finished
  localparam logic [3:0] PTR_TOP_LAST = 4'h7; // last slot of the top half
  localparam logic [3:0] PTR_BOT_LAST = 4'hF; // last slot of the bottom half
  localparam logic [3:0] SIZE_RST = 4'h0; // size one frame
endpackage
`default_nettype wire

// >>> verilog/qsq_top.sv
// qsq_top: 16-frame transmit and receive queues for one serial channel.
// assumes the shifters, baud logic and framing sit outside on mclk.
//
// What this block does
// - tx_queue_en selects queued transmit mode
// - queue off: single buffer, slots are registers
// - wrap restarts at slot zero, self-clears
// - top-half-empty sets on slots 0..7 drained
// - bottom-half-empty sets on slots 8..15 drained
// - tx half-empty interrupts gated by own enables
// - 4-bit size field, rewritable during transmit
// - pending counter counts down, rolls to ones
// - tx pointer writable only in test mode
// - queued completion at pending ones, shifter idle
// - data register writes ignored in queued transmit
// - rx queue off: single buffer, slots are registers
// - errored frames skipped, queue blocked until cleared
// - rx half-full flags, read then write-zero clear
// - rx half-full interrupts gated by own enables
// - rx pointer marks next store location
// - full target half: queue overrun, disable queue
// - noisy frames stored; noise and idle clear
// - sixteen frames: both full, pointer zero
`timescale 1ns/1ns
`default_nettype none
module qsq_top (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [qsq_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [qsq_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [qsq_pkg::DATA_W-1:0] reg_rdata_q,
  input wire logic tx_shifter_empty,
  output logic tx_load_q,
  output logic [qsq_pkg::FRAME_W-1:0] tx_frame_q,
  input wire logic rx_frame_strobe,
  input wire logic [qsq_pkg::FRAME_W-1:0] rx_frame,
  input wire logic rx_framing_err,
  input wire logic rx_parity_err,
  input wire logic rx_noise,
  input wire logic rx_idle_seen,
  output logic irq_q
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [8:0] tx_slot_q [16]; // tx_queue_slot storage
  logic [8:0] rx_slot_q [16]; // rx_queue_slot storage
  logic [15:0] qctrl_q; // queue control bits
  logic [2:0] cctrl_q; // xmit_on, rx_on, line_quiet_irq_en
  logic [3:0] frames_pending_q;
  logic [3:0] tx_queue_pointer_q;
  logic [3:0] rx_queue_pointer_q;
  logic [8:0] tx_dr_q; // transmit side of channel_data_reg
  logic [8:0] rx_dr_q; // receive side of channel_data_reg
  logic tx_data_empty_q;
  logic rx_data_full_q;
  logic [4:0] qflag_q; // overrun, rx full x2, tx empty x2
  logic [4:0] qarm_q; // armed by a status read with flag set
  logic [7:1] cflag_q; // channel flags beyond tx_data_empty
  logic [7:1] carm_q;
  logic done_prev_q; // completion condition, one cycle late
  logic tx_active_q; // set in flight; pending all ones also means sixteen to go
  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic wr_qctrl, wr_qstat, wr_cctrl, wr_cdata, wr_txs, wr_rxs;
  logic rd_qstat, rd_cstat, rd_cdata, rd_rxs;
  logic tx_queue_en, rx_queue_en, tx_wrap_en, test_mode, xmit_on, rx_on;
  logic [3:0] tx_queue_size;
  logic tx_move, tx_wrap, tx_start, tx_load_go, done_cond, done_set;
  logic rx_ready, rx_target_full, rx_move, rx_block;
  logic [4:0] qclr;
  logic [31:0] rdata_d;

  assign wr_qctrl = reg_wr && reg_addr == qsq_pkg::A_QCTRL;
  assign wr_qstat = reg_wr && reg_addr == qsq_pkg::A_QSTAT;
  assign wr_cctrl = reg_wr && reg_addr == qsq_pkg::A_CCTRL;
  assign wr_cdata = reg_wr && reg_addr == qsq_pkg::A_CDATA;
  assign wr_txs = reg_wr && reg_addr[5:4] == qsq_pkg::A_TXSLOT;
  assign wr_rxs = reg_wr && reg_addr[5:4] == qsq_pkg::A_RXSLOT;
  assign rd_qstat = reg_rd && reg_addr == qsq_pkg::A_QSTAT;
  assign rd_cstat = reg_rd && reg_addr == qsq_pkg::A_CSTAT;
  assign rd_cdata = reg_rd && reg_addr == qsq_pkg::A_CDATA;
  assign rd_rxs = reg_rd && reg_addr[5:4] == qsq_pkg::A_RXSLOT;

  assign tx_queue_en = qctrl_q[qsq_pkg::QC_TXQEN];
  assign rx_queue_en = qctrl_q[qsq_pkg::QC_RXQEN];
  assign tx_wrap_en = qctrl_q[qsq_pkg::QC_WRAP];
  assign test_mode = qctrl_q[qsq_pkg::QC_TEST];
  assign tx_queue_size = qctrl_q[qsq_pkg::QC_SIZE +: 4];
  assign xmit_on = cctrl_q[qsq_pkg::CC_XON];
  assign rx_on = cctrl_q[qsq_pkg::CC_RON];

  // ----------------------------------------------------------------
  // transmit sequencing
  // ----------------------------------------------------------------
  // queue starts when software raises tx_queue_en
  assign tx_start = wr_qctrl && reg_wdata[qsq_pkg::QC_TXQEN] && !tx_queue_en;
  // next slot moves into the data register while the set is in flight
  assign tx_move = tx_queue_en && xmit_on && tx_data_empty_q && !tx_start && tx_active_q;
  // last frame of the set with wrap armed restarts at slot zero
  assign tx_wrap = tx_move && frames_pending_q == 4'h0 && tx_wrap_en;
  // shifter takes the data register; hold off one cycle after a load
  assign tx_load_go = xmit_on && !tx_data_empty_q && tx_shifter_empty && !tx_load_q;
  // completion: queue drained (or single buffer empty) and shifter idle
  assign done_cond = tx_data_empty_q && tx_shifter_empty && !tx_load_q
                     && (!tx_queue_en || (!tx_active_q && frames_pending_q == qsq_pkg::PEND_DONE));
  // flag sets on the rising edge so a clear can stick
  assign done_set = done_cond && !done_prev_q;

  // ----------------------------------------------------------------
  // receive sequencing
  // ----------------------------------------------------------------
  // errored frame in the data register blocks the queue
  assign rx_ready = rx_queue_en && rx_on && rx_data_full_q
                    && !cflag_q[qsq_pkg::CS_FRM] && !cflag_q[qsq_pkg::CS_PAR];
  assign rx_target_full = rx_queue_pointer_q[3] ? qflag_q[qsq_pkg::QS_RBF]
                                                 : qflag_q[qsq_pkg::QS_RTF];
  assign rx_move = rx_ready && !rx_target_full;
  assign rx_block = rx_ready && rx_target_full;

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // wrap bit cleared by hardware unless software rewrites it together
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      qctrl_q <= {4'h0, qsq_pkg::SIZE_RST, 8'h00};
    end else begin
      if (tx_wrap) begin
        qctrl_q[qsq_pkg::QC_WRAP] <= 1'b0;
      end
      if (rx_block) begin
        qctrl_q[qsq_pkg::QC_RXQEN] <= 1'b0;
      end
      if (wr_qctrl) begin
        qctrl_q <= {4'h0, reg_wdata[11:0]};
      end
    end
  end

  // channel enables
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cctrl_q <= 3'h0;
    end else if (wr_cctrl) begin
      cctrl_q <= reg_wdata[2:0];
    end
  end

  // ----------------------------------------------------------------
  // queue storage
  // ----------------------------------------------------------------
  // tx slots are plain registers to software in every mode
  always_ff @(posedge mclk) begin
    if (wr_txs) begin
      tx_slot_q[reg_addr[3:0]] <= reg_wdata[8:0];
    end
  end

  // rx slots: a hardware store wins over a software write
  always_ff @(posedge mclk) begin
    if (rx_move) begin
      rx_slot_q[rx_queue_pointer_q] <= rx_dr_q;
    end else if (wr_rxs) begin
      rx_slot_q[reg_addr[3:0]] <= reg_wdata[8:0];
    end
  end

  // ----------------------------------------------------------------
  // pending count and pointers
  // ----------------------------------------------------------------
  // test-mode writes go through the queue status register
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      frames_pending_q <= qsq_pkg::PEND_DONE;
      tx_queue_pointer_q <= 4'h0;
    end else if (tx_start) begin
      frames_pending_q <= reg_wdata[qsq_pkg::QC_SIZE +: 4];
      tx_queue_pointer_q <= 4'h0;
    end else if (tx_wrap) begin
      frames_pending_q <= tx_queue_size;
      tx_queue_pointer_q <= 4'h0;
    end else if (tx_move) begin
      frames_pending_q <= frames_pending_q - 4'h1;
      tx_queue_pointer_q <= tx_queue_pointer_q + 4'h1;
    end else if (wr_qstat && test_mode) begin
      frames_pending_q <= reg_wdata[qsq_pkg::QS_PEND +: 4];
      tx_queue_pointer_q <= reg_wdata[qsq_pkg::QS_TPTR +: 4];
    end
  end

  // set in flight from start or wrap until its last frame leaves
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tx_active_q <= 1'b0;
    end else if (tx_start || tx_wrap) begin
      tx_active_q <= 1'b1;
    end else if (!tx_queue_en || (tx_move && frames_pending_q == 4'h0)) begin
      tx_active_q <= 1'b0;
    end
  end

  // rx pointer wraps naturally after slot fifteen
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rx_queue_pointer_q <= 4'h0;
    end else if (rx_move) begin
      rx_queue_pointer_q <= rx_queue_pointer_q + 4'h1;
    end else if (wr_qstat && test_mode) begin
      rx_queue_pointer_q <= reg_wdata[qsq_pkg::QS_RPTR +: 4];
    end
  end

  // ----------------------------------------------------------------
  // transmit data register and shifter hand-off
  // ----------------------------------------------------------------
  // software writes only reach it with the queue off
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tx_dr_q <= 9'h000;
      tx_data_empty_q <= 1'b1;
    end else if (tx_move) begin
      tx_dr_q <= tx_slot_q[tx_queue_pointer_q];
      tx_data_empty_q <= 1'b0;
    end else if (wr_cdata && !tx_queue_en) begin
      tx_dr_q <= reg_wdata[8:0];
      tx_data_empty_q <= 1'b0;
    end else if (tx_load_go) begin
      tx_data_empty_q <= 1'b1;
    end
  end

  // one-cycle load pulse toward the shifter
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tx_load_q <= 1'b0;
      tx_frame_q <= 9'h000;
      done_prev_q <= 1'b1;
    end else begin
      tx_load_q <= tx_load_go;
      done_prev_q <= done_cond;
      if (tx_load_go) begin
        tx_frame_q <= tx_dr_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // receive data register
  // ----------------------------------------------------------------
  // a frame arriving while full is dropped and flags overrun
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rx_dr_q <= 9'h000;
      rx_data_full_q <= 1'b0;
    end else if (rx_frame_strobe && !rx_data_full_q) begin
      rx_dr_q <= rx_frame;
      rx_data_full_q <= 1'b1;
    end else if (rx_move || rd_cdata) begin
      rx_data_full_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // queue status flags: read with flag set, then write zero
  // ----------------------------------------------------------------
  assign qclr = qarm_q & ~reg_wdata[4:0] & {5{wr_qstat}};

  // arming follows each status read; any status write disarms
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      qarm_q <= 5'h00;
    end else if (rd_qstat) begin
      qarm_q <= qflag_q;
    end else if (wr_qstat) begin
      qarm_q <= 5'h00;
    end
  end

  // set terms come last so an event in the clearing cycle survives
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      qflag_q <= 5'h00;
    end else begin
      qflag_q <= qflag_q & ~qclr;
      if (rx_block) begin
        qflag_q[qsq_pkg::QS_OVR] <= 1'b1;
      end
      if (rx_move && rx_queue_pointer_q == qsq_pkg::PTR_TOP_LAST) begin
        qflag_q[qsq_pkg::QS_RTF] <= 1'b1;
      end
      if (rx_move && rx_queue_pointer_q == qsq_pkg::PTR_BOT_LAST) begin
        qflag_q[qsq_pkg::QS_RBF] <= 1'b1;
      end
      if ((tx_move && tx_queue_pointer_q == qsq_pkg::PTR_TOP_LAST) || (done_set && tx_queue_en)) begin
        qflag_q[qsq_pkg::QS_TTE] <= 1'b1;
      end
      if ((tx_move && tx_queue_pointer_q == qsq_pkg::PTR_BOT_LAST) || (done_set && tx_queue_en)) begin
        qflag_q[qsq_pkg::QS_TBE] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // channel status flags
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      carm_q <= 7'h00;
    end else if (rd_cstat) begin
      carm_q <= cflag_q;
    end
  end

  // completion clears on a tx slot or data write; rx errors on data read;
  // noise and idle on a data or rx queue slot read
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cflag_q <= 7'h00;
    end else begin
      if (carm_q[qsq_pkg::CS_DONE] && (wr_txs || wr_cdata)) begin
        cflag_q[qsq_pkg::CS_DONE] <= 1'b0;
      end
      if (rd_cdata) begin
        cflag_q[qsq_pkg::CS_OVR] <= cflag_q[qsq_pkg::CS_OVR] & ~carm_q[qsq_pkg::CS_OVR];
        cflag_q[qsq_pkg::CS_FRM] <= cflag_q[qsq_pkg::CS_FRM] & ~carm_q[qsq_pkg::CS_FRM];
        cflag_q[qsq_pkg::CS_PAR] <= cflag_q[qsq_pkg::CS_PAR] & ~carm_q[qsq_pkg::CS_PAR];
      end
      if (rd_cdata || rd_rxs) begin
        cflag_q[qsq_pkg::CS_IDLE] <= cflag_q[qsq_pkg::CS_IDLE] & ~carm_q[qsq_pkg::CS_IDLE];
        cflag_q[qsq_pkg::CS_NOISE] <= cflag_q[qsq_pkg::CS_NOISE] & ~carm_q[qsq_pkg::CS_NOISE];
      end
      cflag_q[qsq_pkg::CS_RXF] <= rx_data_full_q;
      if (done_set) begin
        cflag_q[qsq_pkg::CS_DONE] <= 1'b1;
      end
      if (rx_idle_seen) begin
        cflag_q[qsq_pkg::CS_IDLE] <= 1'b1;
      end
      if (rx_frame_strobe && rx_data_full_q) begin
        cflag_q[qsq_pkg::CS_OVR] <= 1'b1;
      end
      if (rx_frame_strobe && !rx_data_full_q) begin
        if (rx_noise) begin
          cflag_q[qsq_pkg::CS_NOISE] <= 1'b1;
        end
        if (rx_framing_err) begin
          cflag_q[qsq_pkg::CS_FRM] <= 1'b1;
        end
        if (rx_parity_err) begin
          cflag_q[qsq_pkg::CS_PAR] <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt and read data
  // ----------------------------------------------------------------
  // each half flag reaches the line only through its own enable
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (qflag_q[qsq_pkg::QS_TTE] && qctrl_q[qsq_pkg::QC_TTIE])
            || (qflag_q[qsq_pkg::QS_TBE] && qctrl_q[qsq_pkg::QC_TBIE])
            || (qflag_q[qsq_pkg::QS_RTF] && qctrl_q[qsq_pkg::QC_RTIE])
            || (qflag_q[qsq_pkg::QS_RBF] && qctrl_q[qsq_pkg::QC_RBIE])
            || (cflag_q[qsq_pkg::CS_IDLE] && cctrl_q[qsq_pkg::CC_QIE]);
    end
  end

  // unmapped words read as zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (reg_addr == qsq_pkg::A_QCTRL) begin
      rdata_d[15:0] = qctrl_q;
    end else if (reg_addr == qsq_pkg::A_QSTAT) begin
      rdata_d[4:0] = qflag_q;
      rdata_d[qsq_pkg::QS_RPTR +: 4] = rx_queue_pointer_q;
      rdata_d[qsq_pkg::QS_PEND +: 4] = frames_pending_q;
      rdata_d[qsq_pkg::QS_TPTR +: 4] = tx_queue_pointer_q;
    end else if (reg_addr == qsq_pkg::A_CCTRL) begin
      rdata_d[2:0] = cctrl_q;
    end else if (reg_addr == qsq_pkg::A_CSTAT) begin
      rdata_d[7:0] = {cflag_q, tx_data_empty_q};
    end else if (reg_addr == qsq_pkg::A_CDATA) begin
      rdata_d[8:0] = rx_dr_q;
    end else if (reg_addr[5:4] == qsq_pkg::A_TXSLOT) begin
      rdata_d[8:0] = tx_slot_q[reg_addr[3:0]];
    end else if (reg_addr[5:4] == qsq_pkg::A_RXSLOT) begin
      rdata_d[8:0] = rx_slot_q[reg_addr[3:0]];
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_q <= 32'h0000_0000;
    end else begin
      reg_rdata_q <= reg_rd ? rdata_d : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_tx_ptr_step: assert property (tx_move && !tx_wrap |=> tx_queue_pointer_q == $past(tx_queue_pointer_q) + 4'h1)
    else $error("tx pointer did not step");
  a_pend_roll: assert property (tx_move && !tx_wrap && frames_pending_q == 4'h0 |=> frames_pending_q == 4'hF)
    else $error("pending count did not roll over");
  a_wrap_restart: assert property (tx_wrap |=> !tx_wrap_en && tx_queue_pointer_q == 4'h0)
    else $error("wrap did not restart or clear");
  a_dr_write_ignored: assert property (wr_cdata && tx_queue_en && !tx_move |=> $stable(tx_dr_q))
    else $error("data write took effect in queued mode");
  a_top_empty_set: assert property (tx_move && tx_queue_pointer_q == 4'h7 |=> qflag_q[qsq_pkg::QS_TTE])
    else $error("top half empty not set");
  a_bot_empty_set: assert property (tx_move && tx_queue_pointer_q == 4'hF |=> qflag_q[qsq_pkg::QS_TBE])
    else $error("bottom half empty not set");
  a_done_set: assert property (done_set |=> cflag_q[qsq_pkg::CS_DONE])
    else $error("completion not flagged");
  a_irq_gated: assert property (irq_q |-> $past(|(qflag_q[4:1] & {qctrl_q[4:3], qctrl_q[6:5]}))
                                || $past(cflag_q[qsq_pkg::CS_IDLE] && cctrl_q[qsq_pkg::CC_QIE]))
    else $error("interrupt without enabled flag");
  a_rx_err_skip: assert property (rx_frame_strobe && !rx_data_full_q && rx_framing_err
                                  |=> $stable(rx_queue_pointer_q) [*3])
    else $error("errored frame entered queue");
  a_rx_overrun: assert property (rx_block |=> qflag_q[qsq_pkg::QS_OVR] && !rx_queue_en)
    else $error("queue overrun not handled");
  a_rx_full16: assert property (rx_move && rx_queue_pointer_q == 4'hF && qflag_q[qsq_pkg::QS_RTF]
                                |=> rx_queue_pointer_q == 4'h0 && qflag_q[2:1] == 2'h3)
    else $error("full fill state wrong");

  c_tx_wrap: cover property (tx_wrap);
  c_rx_overrun: cover property (rx_block);
  c_rx_full: cover property (rx_move && rx_queue_pointer_q == 4'hF);
  c_tx_done: cover property (done_set && tx_queue_en);
endmodule // qsq_top
`default_nettype wire

// >>> verification/qsq_remote.sv
// qsq_remote: far-side shifter and remote sender facing qsq_top.
// assumes one mclk; frames move whole, bit timing is not modelled.
`timescale 1ns/1ns
`default_nettype none
module qsq_remote (
  input wire logic mclk,
  input wire logic tx_load_q,
  input wire logic [8:0] tx_frame_q,
  output logic tx_shifter_empty,
  output logic rx_frame_strobe,
  output logic [8:0] rx_frame,
  output logic rx_framing_err,
  output logic rx_parity_err,
  output logic rx_noise,
  output logic rx_idle_seen
);
  logic [3:0] busy_q = 4'h0; // shift cycles left
  logic [8:0] got[$]; // frames taken off the line
  initial {rx_frame_strobe, rx_frame, rx_idle_seen, rx_noise, rx_parity_err, rx_framing_err} = 14'h0000;
  assign tx_shifter_empty = (busy_q == 4'h0);
  // stays busy a while after each load, like a real shifter
  always @(posedge mclk) begin
    if (tx_load_q) begin
      busy_q <= 4'h9;
      got.push_back(tx_frame_q);
    end else if (busy_q != 4'h0) begin
      busy_q <= busy_q - 4'h1;
    end
  end
  // one strobe per frame; e is {idle, noise, parity, framing}
  // qualifiers released to the inverse; idle is a bare pulse, so back to 0
  task automatic send(input logic [8:0] f, input logic [3:0] e);
    @(posedge mclk);
    {rx_frame_strobe, rx_frame, rx_idle_seen, rx_noise, rx_parity_err, rx_framing_err} <= {1'b1, f, e};
    @(posedge mclk);
    {rx_frame_strobe, rx_frame, rx_idle_seen, rx_noise, rx_parity_err, rx_framing_err} <= {1'b0, ~f, 1'b0, ~e[2:0]};
  endtask
endmodule // qsq_remote
`default_nettype wire

// >>> verification/qsq_top_tb.sv
// qsq_top_tb: self-checking bench for the queued serial buffers.
// assumes qsq_pkg, qsq_top and qsq_remote are compiled first.
`timescale 1ns/1ns
`default_nettype none
module qsq_top_tb;
  typedef struct packed {logic w; logic [5:0] a; logic [31:0] d;} qsq_row_t;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [5:0] reg_addr = 6'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata_q, d;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic tx_shifter_empty, tx_load_q, rx_frame_strobe, rx_framing_err, irq_q;
  logic rx_parity_err, rx_noise, rx_idle_seen;
  logic [8:0] tx_frame_q, rx_frame;
  int n_mismatch = 0, n_checks = 0;
  // writes and reads with expected data; queues are off here
  qsq_row_t rows[10] = '{'{1'b0, 6'h01, 32'h0000F000}, '{1'b0, 6'h03, 32'h1}, '{1'b1, 6'h3F, 32'h1234},
    '{1'b0, 6'h3F, 32'h0}, '{1'b1, 6'h13, 32'h1A5}, '{1'b0, 6'h13, 32'h1A5}, '{1'b1, 6'h25, 32'hAA},
    '{1'b0, 6'h25, 32'hAA}, '{1'b1, 6'h01, 32'h000F0F00}, '{1'b0, 6'h01, 32'h0000F000}};
  always #10 mclk = ~mclk;
  qsq_top u_qsq_top (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .tx_shifter_empty(tx_shifter_empty), .tx_load_q(tx_load_q),
    .tx_frame_q(tx_frame_q), .rx_frame_strobe(rx_frame_strobe), .rx_frame(rx_frame),
    .rx_framing_err(rx_framing_err), .rx_parity_err(rx_parity_err), .rx_noise(rx_noise),
    .rx_idle_seen(rx_idle_seen), .irq_q(irq_q));
  qsq_remote u_qsq_remote (.mclk(mclk), .tx_load_q(tx_load_q), .tx_frame_q(tx_frame_q),
    .tx_shifter_empty(tx_shifter_empty), .rx_frame_strobe(rx_frame_strobe), .rx_frame(rx_frame),
    .rx_framing_err(rx_framing_err), .rx_parity_err(rx_parity_err), .rx_noise(rx_noise),
    .rx_idle_seen(rx_idle_seen));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one strobe cycle; read data taken the cycle after the strobe
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] v);
    @(posedge mclk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, ~w, a, v};
    @(posedge mclk);
    {reg_wr, reg_rd} <= 2'b00;
    #1 d = reg_rdata_q;
  endtask
  task automatic results();
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // watchdog well past the few hundred cycles the tests need
  initial begin
    #100000;
    n_mismatch++;
    results();
  end
  initial begin
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      bus(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk(d, rows[i].d);
    end
    // two-frame queued send; data reg write must be dropped
    bus(1'b1, 6'h10, 32'h101);
    bus(1'b1, 6'h11, 32'h0F2);
    bus(1'b1, 6'h02, 32'h1);
    bus(1'b1, 6'h00, 32'h101);
    bus(1'b1, 6'h04, 32'h055);
    for (int i = 0; i < 300 && !(u_qsq_remote.got.size() == 2 && tx_shifter_empty); i++)
      @(posedge mclk);
    repeat (4) @(posedge mclk);
    chk(u_qsq_remote.got.size(), 2);
    chk(u_qsq_remote.got[0], 32'h101);
    chk(u_qsq_remote.got[1], 32'h0F2);
    bus(1'b0, 6'h03, 32'h0);
    chk(d, 32'h3);
    bus(1'b1, 6'h10, 32'h0);
    bus(1'b0, 6'h03, 32'h0);
    chk(d, 32'h1);
    bus(1'b0, 6'h01, 32'h0);
    chk(d, 32'h0002F018);
    bus(1'b1, 6'h01, 32'h10);
    bus(1'b0, 6'h01, 32'h0);
    chk(d, 32'h0002F010);
    chk(irq_q, 32'h0);
    bus(1'b1, 6'h00, 32'h111);
    bus(1'b0, 6'h01, 32'h0);
    chk(irq_q, 32'h1);
    // receive: clean and noisy frames stored, errored frame skipped
    bus(1'b1, 6'h02, 32'h3);
    bus(1'b1, 6'h00, 32'h113);
    u_qsq_remote.send(9'h1C3, 4'h0);
    repeat (4) @(posedge mclk);
    bus(1'b0, 6'h20, 32'h0);
    chk(d, 32'h1C3);
    u_qsq_remote.send(9'h15A, 4'hC);
    repeat (4) @(posedge mclk);
    bus(1'b0, 6'h03, 32'h0);
    chk(d, 32'h29);
    bus(1'b0, 6'h21, 32'h0);
    chk(d, 32'h15A);
    bus(1'b0, 6'h03, 32'h0);
    chk(d, 32'h1);
    u_qsq_remote.send(9'h0E7, 4'h3);
    repeat (4) @(posedge mclk);
    bus(1'b0, 6'h01, 32'h0);
    chk(d[11:8], 32'h2);
    bus(1'b0, 6'h03, 32'h0);
    chk(d, 32'hC5);
    bus(1'b0, 6'h04, 32'h0);
    chk(d, 32'h0E7);
    // fill the rest of the queue, then one frame too many
    for (int i = 2; i < 17; i++) begin
      u_qsq_remote.send(9'(i + 256), 4'h0);
      repeat (2) @(posedge mclk);
    end
    repeat (4) @(posedge mclk);
    bus(1'b0, 6'h01, 32'h0);
    chk(d, 32'h0002F017);
    bus(1'b0, 6'h2F, 32'h0);
    chk(d, 32'h10F);
    bus(1'b0, 6'h00, 32'h0);
    chk(d, 32'h111);
    bus(1'b0, 6'h04, 32'h0);
    chk(d, 32'h110);
    // sixteen-frame set sent twice through one wrap
    for (int i = 0; i < 16; i++) bus(1'b1, 6'(i + 16), 32'(i + 48));
    bus(1'b1, 6'h00, 32'h0);
    bus(1'b1, 6'h00, 32'hF05);
    for (int i = 0; i < 900 && !(u_qsq_remote.got.size() == 34 && tx_shifter_empty); i++)
      @(posedge mclk);
    repeat (4) @(posedge mclk);
    chk(u_qsq_remote.got.size(), 34);
    chk(u_qsq_remote.got[18], 32'h30);
    chk(u_qsq_remote.got[33], 32'h3F);
    bus(1'b0, 6'h00, 32'h0);
    chk(d, 32'hF01);
    bus(1'b0, 6'h01, 32'h0);
    chk(d, 32'h0000F01F);
    bus(1'b0, 6'h03, 32'h0);
    chk(d, 32'h3);
    results();
  end
endmodule // qsq_top_tb
`default_nettype wire
